/* rtl/cascade_divider.sv */
// one programmable low/high divider with phase offset, start level and bypass
// assumes clk_en marks the input clock edges, all on pclk
`timescale 1ns/10ps
`default_nettype none
module cascade_divider (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       clk_en,
	input  wire logic       clk_lvl,
	input  wire logic [3:0] low_cnt,
	input  wire logic [3:0] high_cnt,
	input  wire logic [3:0] phase,
	input  wire logic       start_high,
	input  wire logic       bypass,
	input  wire logic       restart,
	output logic            div_out
);
	typedef struct packed {
		logic       lvl;
		logic [3:0] cnt;
		logic [3:0] delay;
	} div_state_t;
	div_state_t s_q, s_d;

	always_comb begin
		s_d = s_q;
		if (restart) begin
			s_d.lvl   = start_high;
			s_d.cnt   = 4'h0;
			s_d.delay = phase;
		end else if (clk_en && !bypass) begin
			if (s_q.delay != 4'h0) begin
				s_d.delay = s_q.delay - 4'h1;
			end else if (s_q.lvl) begin
				if (s_q.cnt >= high_cnt) begin
					s_d.lvl = 1'b0;
					s_d.cnt = 4'h0;
				end else begin
					s_d.cnt = s_q.cnt + 4'h1;
				end
			end else begin
				if (s_q.cnt >= low_cnt) begin
					s_d.lvl = 1'b1;
					s_d.cnt = 4'h0;
				end else begin
					s_d.cnt = s_q.cnt + 4'h1;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// bypass forwards the input level; counting is frozen meanwhile
	assign div_out = bypass ? clk_lvl : s_q.lvl;
endmodule
`default_nettype wire

/* rtl/channel_and_prescale_dividers.sv */
// channel cascaded dividers and prescale divider behind an APB register file
// assumes a 25 MHz pclk; clock input is modelled as a level sampled on pin
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - second divider stays low for low field plus one input cycles
// - second divider stays high for high field plus one input cycles
// - four-bit phase offset for second divider in bits 7 to 4
// - four-bit phase offset for first divider in bits 3 to 0
// - bypass bit 5 passes input clock straight to second divider output
// - bypass bit 4 passes input clock straight to first divider output
// - sync-ignore bit 3 makes dividers disregard the chip sync request
// - bit 2 gives forced high output during a sync request, only while sync-ignore is set
// - bit 1 sets second divider start level after sync
// - bit 0 sets first divider start level
// - duty correction applies while disable bit 0 is clear
// - prescale codes 0 to 4 divide by 2 to 6, others static
// - input power bit 4 powers down whole clock input section
// - input power bit 3 powers down oscillator to distribution interface
// - settings other than the soft sync bit go active only when the self-clearing update bit is written
module channel_and_prescale_dividers import clkdiv_pkg::*; (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic        clk_in_pin,
	input  wire logic        sync_n_pin,
	output logic             prescale_out,
	output logic             ch_out,
	output logic             duty_fix_on,
	output logic             input_section_on,
	output logic             osc_if_on
);
	typedef struct packed {
		logic [7:0] phase;
		logic [7:0] second;
		logic [7:0] first;
		logic [7:0] ctrl;
		logic [7:0] duty;
		logic [7:0] pre;
		logic [7:0] power;
	} regset_t;

	typedef struct packed {
		regset_t    buf_r;
		regset_t    act;
		logic       soft_sync;
		logic [1:0] clk_sync;
		logic [1:0] syn_sync;
		logic       clk_prev;
		logic       d1_prev;
		logic [2:0] pre_cnt;
		logic       pre_lvl;
		logic       pready;
		logic [31:0] prdata;
		logic       pslverr;
		logic       ch_out;
		logic       pre_out;
		logic       duty_on;
		logic       in_on;
		logic       osc_on;
	} top_state_t;

	top_state_t s_q, s_d;

	logic        d1_out;
	logic        d2_out;
	logic        d1_en;
	logic        restart;
	logic        sync_req;
	logic        in_rise;

	function automatic logic [9:0] word_index(input logic [11:0] a);
		word_index = a[11:2];
	endfunction

	function automatic logic [2:0] pre_limit(input logic [2:0] code);
		// count of input edges per half period index for ratios 2..6
		pre_limit = code;
	endfunction

	// sync request: pin low or soft sync bit set holds dividers
	assign sync_req = !s_q.syn_sync[1] || s_q.soft_sync;
	// ignored when sync-ignore is set
	assign restart  = sync_req && !s_q.act.ctrl[BIT_NOSYNC];
	// powered-down input section stops all edges
	assign in_rise  = s_q.clk_sync[1] && !s_q.clk_prev && !s_q.act.power[BIT_PD_INPUT];
	// first divider runs from prescale output edges
	assign d1_en    = in_rise && s_q.pre_cnt == 3'h0 && !s_q.pre_lvl
		&& s_q.act.pre[2:0] < PRE_STATIC_MIN;

	cascade_divider u_div1 (
		.pclk       (pclk),
		.presetn    (presetn),
		.clk_en     (d1_en),
		.clk_lvl    (s_q.pre_lvl),
		.low_cnt    (s_q.act.first[LOW_MSB:LOW_LSB]),
		.high_cnt   (s_q.act.first[HIGH_MSB:HIGH_LSB]),
		.phase      (s_q.act.phase[HIGH_MSB:HIGH_LSB]),
		.start_high (s_q.act.ctrl[BIT_START1]),
		.bypass     (s_q.act.ctrl[BIT_BYP1]),
		.restart    (restart),
		.div_out    (d1_out)
	);

	logic d2_en;
	// second divider counts first divider rising edges
	assign d2_en = d1_out && !s_q.d1_prev;

	cascade_divider u_div2 (
		.pclk       (pclk),
		.presetn    (presetn),
		.clk_en     (d2_en),
		.clk_lvl    (d1_out),
		.low_cnt    (s_q.act.second[LOW_MSB:LOW_LSB]),
		.high_cnt   (s_q.act.second[HIGH_MSB:HIGH_LSB]),
		.phase      (s_q.act.phase[LOW_MSB:LOW_LSB]),
		.start_high (s_q.act.ctrl[BIT_START2]),
		.bypass     (s_q.act.ctrl[BIT_BYP2]),
		.restart    (restart),
		.div_out    (d2_out)
	);

	always_comb begin
		logic        access;
		logic [9:0]  idx;
		logic        hit;
		s_d     = s_q;
		access  = psel && penable && !s_q.pready;
		idx     = word_index(paddr);
		hit     = 1'b0;
		s_d.pready  = access;
		s_d.pslverr = 1'b0;
		// two-flop synchronisers for pin inputs
		s_d.clk_sync = {s_q.clk_sync[0], clk_in_pin};
		s_d.syn_sync = {s_q.syn_sync[0], sync_n_pin};
		s_d.clk_prev = s_q.clk_sync[1];
		s_d.d1_prev = d1_out;

		// prescale divider: ratio code+2, split low/high
		if (s_q.act.pre[2:0] >= PRE_STATIC_MIN) begin
			s_d.pre_lvl = 1'b0;
			s_d.pre_cnt = 3'h0;
		end else if (in_rise) begin
			if (s_q.pre_cnt == 3'h0) begin
				// high phase one edge longer on odd ratios, which duty fix smooths
				s_d.pre_lvl = !s_q.pre_lvl;
				s_d.pre_cnt = s_q.pre_lvl ? pre_limit(3'(s_q.act.pre[2:0] >> 1))
					: pre_limit(3'((s_q.act.pre[2:0] + 3'h1) >> 1));
			end else begin
				s_d.pre_cnt = s_q.pre_cnt - 3'h1;
			end
		end

		// outputs
		// power-down wins over the forced level, the tree is dark
		if (s_q.act.power[BIT_PD_INPUT]) begin
			s_d.ch_out = 1'b0;
		end else if (s_q.act.ctrl[BIT_NOSYNC] && s_q.act.ctrl[BIT_FORCE] && sync_req) begin
			s_d.ch_out = 1'b1;
		end else begin
			s_d.ch_out = d2_out;
		end
		s_d.pre_out = s_q.pre_lvl && !s_q.act.power[BIT_PD_INPUT];
		s_d.duty_on = !s_q.act.duty[BIT_DUTY_OFF];
		s_d.in_on   = !s_q.act.power[BIT_PD_INPUT];
		s_d.osc_on  = !s_q.act.power[BIT_PD_OSCIF] && !s_q.act.power[BIT_PD_INPUT];

		// apb access
		if (access) begin
			s_d.prdata = 32'h0000_0000;
			unique case (idx)
				IDX_PHASE: begin
					hit = 1'b1;
					s_d.prdata[7:0] = s_q.buf_r.phase;
					if (pwrite) s_d.buf_r.phase = pwdata[7:0];
				end
				IDX_SECOND: begin
					hit = 1'b1;
					s_d.prdata[7:0] = s_q.buf_r.second;
					if (pwrite) s_d.buf_r.second = pwdata[7:0];
				end
				IDX_FIRST: begin
					hit = 1'b1;
					s_d.prdata[7:0] = s_q.buf_r.first;
					if (pwrite) s_d.buf_r.first = pwdata[7:0];
				end
				IDX_CTRL: begin
					hit = 1'b1;
					s_d.prdata[7:0] = s_q.buf_r.ctrl;
					if (pwrite) s_d.buf_r.ctrl = {2'b00, pwdata[5:0]};
				end
				IDX_DUTY: begin
					hit = 1'b1;
					s_d.prdata[7:0] = s_q.buf_r.duty;
					if (pwrite) s_d.buf_r.duty = {7'h00, pwdata[BIT_DUTY_OFF]};
				end
				IDX_PRESCALE: begin
					hit = 1'b1;
					s_d.prdata[7:0] = s_q.buf_r.pre;
					// static codes are taken as written; calibration order is software's job
					if (pwrite) s_d.buf_r.pre = {5'h00, pwdata[2:0]};
				end
				IDX_POWER: begin
					hit = 1'b1;
					s_d.prdata[7:0] = s_q.buf_r.power;
					if (pwrite) s_d.buf_r.power = {3'h0, pwdata[4:0]};
				end
				IDX_SYNC: begin
					hit = 1'b1;
					s_d.prdata[BIT_SOFT_SYNC] = s_q.soft_sync;
					if (pwrite) s_d.soft_sync = pwdata[BIT_SOFT_SYNC];
				end
				IDX_UPDATE: begin
					hit = 1'b1;
					// self-clearing, so reads show zero
					if (pwrite && pwdata[BIT_UPDATE]) s_d.act = s_d.buf_r;
				end
				default: begin
					hit = 1'b0;
				end
			endcase
			s_d.pslverr = !hit;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
			s_q.buf_r.pre <= RST_PRESCALE;
			s_q.act.pre   <= RST_PRESCALE;
			s_q.duty_on   <= 1'b1;
			s_q.in_on     <= 1'b1;
			s_q.osc_on    <= 1'b1;
			s_q.syn_sync  <= 2'b11;
		end else begin
			s_q <= s_d;
		end
	end

	assign pready           = s_q.pready;
	assign prdata           = s_q.prdata;
	assign pslverr          = s_q.pslverr;
	assign prescale_out     = s_q.pre_out;
	assign ch_out           = s_q.ch_out;
	assign duty_fix_on      = s_q.duty_on;
	assign input_section_on = s_q.in_on;
	assign osc_if_on        = s_q.osc_on;
endmodule
`default_nettype wire

/* rtl/clkdiv_pkg.sv */
// constants for the channel and prescale divider block
// assumes a single pclk domain and an APB register slave
package clkdiv_pkg;
	// register word indices (printed offsets are indices, byte address is four times)
	localparam logic [9:0] IDX_PHASE    = 10'h19F;
	localparam logic [9:0] IDX_SECOND   = 10'h1A0;
	localparam logic [9:0] IDX_CTRL     = 10'h1A1;
	localparam logic [9:0] IDX_DUTY     = 10'h1A2;
	localparam logic [9:0] IDX_FIRST    = 10'h1A3;
	localparam logic [9:0] IDX_PRESCALE = 10'h1E0;
	localparam logic [9:0] IDX_POWER    = 10'h1E1;
	localparam logic [9:0] IDX_UPDATE   = 10'h232;
	localparam logic [9:0] IDX_SYNC     = 10'h230;
	// field positions
	localparam int LOW_MSB       = 7;
	localparam int LOW_LSB       = 4;
	localparam int HIGH_MSB      = 3;
	localparam int HIGH_LSB      = 0;
	localparam int BIT_BYP2      = 5;
	localparam int BIT_BYP1      = 4;
	localparam int BIT_NOSYNC    = 3;
	localparam int BIT_FORCE     = 2;
	localparam int BIT_START2    = 1;
	localparam int BIT_START1    = 0;
	localparam int BIT_DUTY_OFF  = 0;
	localparam int BIT_PD_INPUT  = 4;
	localparam int BIT_PD_OSCIF  = 3;
	localparam int BIT_UPDATE    = 0;
	localparam int BIT_SOFT_SYNC = 0;
	// reset values and lowest static prescale code
	localparam logic [7:0] RST_ZERO     = 8'h00;
	localparam logic [7:0] RST_PRESCALE = 8'h02;
	localparam logic [2:0] PRE_STATIC_MIN = 3'h5;
endpackage

/* testbench/clkdiv_assertions.sv */
// port-level checker for the channel and prescale divider block
// assumes only the top module's ports, one pclk domain
`timescale 1ns/10ps
`default_nettype none
module clkdiv_assertions (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic        pready,
	input  wire logic [31:0] prdata,
	input  wire logic        pslverr,
	input  wire logic        clk_in_pin,
	input  wire logic        sync_n_pin,
	input  wire logic        prescale_out,
	input  wire logic        ch_out,
	input  wire logic        duty_fix_on,
	input  wire logic        input_section_on,
	input  wire logic        osc_if_on
);
	logic upd;
	// update strobe seen on the bus, used as the only cause of active changes
	assign upd = psel && penable && pwrite && (paddr == 12'h8C8) && pwdata[0];
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
	chk_ready_wait: assert property (psel && penable && !pready |=> pready) else $error("no answer");
	chk_err_ready: assert property (pslverr |-> pready) else $error("stray pslverr");
	chk_err_data: assert property (pslverr |-> prdata == 32'h0) else $error("error data");
	chk_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper bits");
	chk_duty_update: assert property ($changed(duty_fix_on) |->
		$past(upd, 1) || $past(upd, 2) || $past(upd, 3)) else $error("duty without update");
	chk_power_update: assert property ($changed(input_section_on) |->
		$past(upd, 1) || $past(upd, 2) || $past(upd, 3)) else $error("power without update");
	chk_osc_update: assert property ($changed(osc_if_on) |->
		$past(upd, 1) || $past(upd, 2) || $past(upd, 3)) else $error("osc without update");
	chk_power_off: assert property (!input_section_on [*4] |-> !prescale_out && !ch_out)
		else $error("outputs run while powered down");
	cover property (pslverr);
	cover property (!input_section_on);
	cover property ($fell(ch_out));
endmodule
bind channel_and_prescale_dividers clkdiv_assertions u_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pready(pready), .prdata(prdata), .pslverr(pslverr), .clk_in_pin(clk_in_pin),
	.sync_n_pin(sync_n_pin), .prescale_out(prescale_out), .ch_out(ch_out),
	.duty_fix_on(duty_fix_on), .input_section_on(input_section_on), .osc_if_on(osc_if_on));
`default_nettype wire

/* testbench/testbench.sv */
// self-checking bench: apb register access and divider output timing
// assumes input clock toggles every 4 pclk, so one input period is 8 pclk
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic        pclk, presetn, psel, penable, pwrite, clk_in_pin, sync_n_pin, e;
	logic        pready, pslverr, prescale_out, ch_out, duty_fix_on, input_section_on, osc_if_on;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	int          err_count, tests_run, h, p;
	logic [11:0] ra[6] = '{12'h67C, 12'h680, 12'h684, 12'h688, 12'h780, 12'h784};
	logic [7:0]  rv[6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00};
	// control, second, first, period, high time (0 skips the high check)
	int          ct[5][5] = '{'{16, 33, 0, 80, 32}, '{16, 0, 0, 32, 16}, '{0, 0, 1, 96, 48},
		'{48, 0, 0, 16, 0}, '{32, 0, 1, 48, 32}};
	int          st[5][2] = '{'{0, 0}, '{2, 1}, '{12, 1}, '{4, 0}, '{33, 1}};
	channel_and_prescale_dividers i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .clk_in_pin(clk_in_pin), .sync_n_pin(sync_n_pin),
		.prescale_out(prescale_out), .ch_out(ch_out), .duty_fix_on(duty_fix_on),
		.input_section_on(input_section_on), .osc_if_on(osc_if_on));
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	initial forever begin
		repeat (4) @(posedge pclk);
		clk_in_pin <= ~clk_in_pin;
	end
	task finish_test;
		$display("checks %0d errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] x, input logic [31:0] g);
		tests_run++;
		if (g !== x) begin
			err_count++;
			$display("ERROR %s expected %0h seen %0h", n, x, g);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task upd;
		apb(1'b1, 12'h8C8, 32'h1);
		repeat (4) @(posedge pclk);
	endtask
	// rising edge to rising edge; p stays 0 when the output never rises
	task meas(input logic s);
		int   ph;
		logic v, q;
		ph = 0;
		h = 0;
		p = 0;
		q = 1'b1;
		for (int i = 0; i < 500 && ph < 2; i++) begin
			@(posedge pclk);
			#1;
			v = s ? ch_out : prescale_out;
			if (ph == 1) p++;
			if (v && !q) ph++;
			if (ph == 1) h += int'(v);
			q = v;
		end
	endtask
	initial begin
		repeat (60000) @(posedge pclk);
		err_count++;
		finish_test;
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{clk_in_pin, presetn, err_count, tests_run} = '0;
		sync_n_pin = 1'b1;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		foreach (ra[i]) begin
			apb(1'b0, ra[i], 32'h0);
			chk("reset value", {24'h0, rv[i]}, r);
		end
		chk("duty on", 32'h1, {31'h0, duty_fix_on});
		chk("input on", 32'h1, {31'h0, input_section_on});
		chk("osc on", 32'h1, {31'h0, osc_if_on});
		apb(1'b0, 12'h7FC, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, r);
		apb(1'b1, 12'h67C, 32'h5A);
		apb(1'b0, 12'h67C, 32'h0);
		chk("phase", 32'h5A, r);
		apb(1'b1, 12'h688, 32'h1);
		repeat (4) @(posedge pclk);
		chk("duty before update", 32'h1, {31'h0, duty_fix_on});
		upd;
		chk("duty off", 32'h0, {31'h0, duty_fix_on});
		apb(1'b1, 12'h784, 32'h18);
		upd;
		chk("input off", 32'h0, {31'h0, input_section_on});
		chk("osc off", 32'h0, {31'h0, osc_if_on});
		meas(1'b0);
		chk("powered down", 32'h0, 32'(p));
		apb(1'b1, 12'h784, 32'h0);
		apb(1'b1, 12'h688, 32'h0);
		upd;
		// static codes come last, after all divide codes have run
		for (int c = 0; c < 8; c++) begin
			apb(1'b1, 12'h780, 32'(c));
			upd;
			meas(1'b0);
			meas(1'b0);
			chk("prescale period", c < 5 ? 32'((c + 2) * 8) : 32'h0, 32'(p));
		end
		apb(1'b1, 12'h780, 32'h0);
		foreach (ct[i]) begin
			apb(1'b1, 12'h684, 32'(ct[i][0]));
			apb(1'b1, 12'h680, 32'(ct[i][1]));
			apb(1'b1, 12'h68C, 32'(ct[i][2]));
			upd;
			meas(1'b1);
			meas(1'b1);
			chk("channel period", 32'(ct[i][3]), 32'(p));
			if (ct[i][4] != 0) chk("channel high", 32'(ct[i][4]), 32'(h));
		end
		@(posedge pclk);
		sync_n_pin <= 1'b0;
		foreach (st[i]) begin
			apb(1'b1, 12'h684, 32'(st[i][0]));
			upd;
			repeat (20) @(posedge pclk);
			chk("held level", 32'(st[i][1]), {31'h0, ch_out});
		end
		apb(1'b1, 12'h684, 32'h38);
		upd;
		meas(1'b1);
		meas(1'b1);
		chk("ignores sync", 32'h10, 32'(p));
		@(posedge pclk);
		sync_n_pin <= 1'b1;
		apb(1'b1, 12'h684, 32'h02);
		upd;
		apb(1'b1, 12'h8C0, 32'h1);
		repeat (20) @(posedge pclk);
		chk("soft sync hold", 32'h1, {31'h0, ch_out});
		apb(1'b0, 12'h8C0, 32'h0);
		chk("soft sync read", 32'h1, r);
		finish_test;
	end
endmodule
`default_nettype wire
